/* File: sim/serial_ram_i2c_slave_sva.sv */
// Purpose: line checks on the link between the two ends
// Assumes: bit phases of 33 cycles or more
// Notes: 8-cycle windows never span a legal line change
`timescale 1ns/1ps
`default_nettype none
module serial_ram_i2c_slave_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_m_o,
	input wire logic sda_m_oe,
	input wire logic sda_s_o,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	wire logic m_pull;
	wire logic s_pull;
	assign m_pull = sda_m_oe & ~sda_m_o;
	assign s_pull = sda_s_oe & ~sda_s_o;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	reset_idle_a: assert property ($fell(rst) |-> scl && sda)
		else $error("lines held after reset");
	dev_hold_a: assert property (scl && $past(scl) |-> $stable(s_pull))
		else $error("ram end moved data while clock high");
	master_hold_a: assert property ($rose(scl) |=> $stable(m_pull) [*8])
		else $error("master moved data early in clock high");
	low_min_a: assert property ($fell(scl) |-> !scl [*8])
		else $error("clock low phase too short");
	high_min_a: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	stop_idle_a: assert property ($rose(sda) && scl |-> (sda && scl && !s_pull) [*8])
		else $error("lines not released after stop");
	start_quiet_a: assert property ($fell(sda) && scl |-> (m_pull && !s_pull) [*8])
		else $error("start not from master or ram end answered early");
	no_clash_a: assert property (scl |-> !(s_pull && m_pull))
		else $error("both ends pull data line");
	clock_drive_a: assert property (scl_oe && !scl_o |-> !scl)
		else $error("clock line not low while master pulls it");
endmodule // serial_ram_i2c_slave_sva
`default_nettype wire

/* File: sim/serial_ram_i2c_slave_tb.sv */
// Purpose: master end against ram end over the link
// Assumes: ram straps tied to 5
// Notes: slow mode runs one byte only, it costs some 47k cycles
`timescale 1ns/1ps
`default_nettype none
module serial_ram_i2c_slave_tb;
	localparam logic [1:0] GO = 2'h0, WR = 2'h1, RD = 2'h2, STP = 2'h3;
	logic clock, rst, power_low, power_save, slow_mode, cmd_valid, cmd_ack;
	logic cmd_ready, rsp_valid, rsp_ack, busy;
	logic [1:0] cmd_op;
	logic [7:0] cmd_data, rsp_data, last_word_address;
	logic [8:0] wire_bits;
	logic [7:0] pat [4] = '{8'h3C, 8'hA5, 8'h0F, 8'hC3};
	logic [7:0] bad [4] = '{8'hA4, 8'hBA, 8'hAA, 8'hAA};
	int errors, check_count;
	two_wire_if bus_i ();
	serial_ram_device serial_ram_device_i (.clock(clock), .rst(rst), .power_low(power_low),
		.power_save(power_save), .hardware_address_straps(3'h5), .bus(bus_i),
		.busy(busy), .last_word_address(last_word_address));
	serial_ram_master serial_ram_master_i (.clock(clock), .rst(rst), .slow_mode(slow_mode),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
		.bus(bus_i));
	serial_ram_i2c_slave_sva serial_ram_i2c_slave_sva_i (.clock(clock), .rst(rst),
		.scl_o(bus_i.scl_o), .scl_oe(bus_i.scl_oe), .sda_m_o(bus_i.sda_m_o),
		.sda_m_oe(bus_i.sda_m_oe), .sda_s_o(bus_i.sda_s_o), .sda_s_oe(bus_i.sda_s_oe),
		.scl(bus_i.scl), .sda(bus_i.sda));
	// what the wire carried over the last nine clock pulses
	always @(posedge bus_i.scl) wire_bits <= {wire_bits[7:0], bus_i.sda};
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic end_sim();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wait_sig(ref logic sig, input logic val, input int lim);
		int n;
		n = 0;
		while (sig !== val) begin
			@(negedge clock);
			n++;
			if (n > lim) begin
				errors++;
				end_sim();
			end
		end
	endtask
	// one command; byte commands also check the ninth bit
	task automatic op(input logic [1:0] o, input logic [7:0] d, input logic a, input logic ea);
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_data = d;
		cmd_ack = a;
		wait_sig(cmd_ready, 1'b1, 60000);
		@(negedge clock);
		cmd_valid = 1'b0;
		if (o == WR || o == RD) begin
			wait_sig(rsp_valid, 1'b1, 60000);
			check({8'h00, rsp_ack}, {8'h00, ea});
		end
	endtask
	task automatic stop_idle();
		op(STP, 8'h00, 1'b0, 1'b0);
		wait_sig(cmd_ready, 1'b1, 60000);
		wait_sig(busy, 1'b0, 200);
		check({8'h00, busy}, 9'h000);
	endtask
	initial begin
		rst = 1'b1;
		power_low = 1'b0;
		power_save = 1'b0;
		slow_mode = 1'b0;
		cmd_valid = 1'b0;
		cmd_ack = 1'b0;
		cmd_op = GO;
		cmd_data = 8'h00;
		errors = 0;
		check_count = 0;
		repeat (16) @(negedge clock);
		rst = 1'b0;
		check({7'h00, bus_i.scl, bus_i.sda}, 9'h003);
		// write across the top of memory, four bytes back to back through the fifo
		op(GO, 8'h00, 1'b0, 1'b0);
		op(WR, 8'hAA, 1'b0, 1'b1);
		check(wire_bits, {8'hAA, 1'b0});
		check({8'h00, busy}, 9'h001);
		op(WR, 8'hFE, 1'b0, 1'b1);
		for (int i = 0; i < 4; i++) op(WR, pat[i], 1'b0, 1'b1);
		stop_idle();
		check({1'b0, last_word_address}, 9'h002);
		// set pointer, repeated start, read back, last byte refused
		op(GO, 8'h00, 1'b0, 1'b0);
		op(WR, 8'hAA, 1'b0, 1'b1);
		op(WR, 8'hFE, 1'b0, 1'b1);
		op(GO, 8'h00, 1'b0, 1'b0);
		op(WR, 8'hAB, 1'b0, 1'b1);
		for (int i = 0; i < 4; i++) begin
			op(RD, 8'h00, i < 3, i < 3);
			check({1'b0, rsp_data}, {1'b0, pat[i]});
		end
		check(wire_bits, {pat[3], 1'b1});
		stop_idle();
		// wrong straps, wrong group, supply low, power save: no answer at all
		for (int k = 0; k < 4; k++) begin
			power_low = (k == 2);
			power_save = (k == 3);
			op(GO, 8'h00, 1'b0, 1'b0);
			op(WR, bad[k], 1'b0, 1'b0);
			op(WR, 8'hAA, 1'b0, 1'b0);
			stop_idle();
		end
		power_low = 1'b0;
		power_save = 1'b0;
		// ram end still answers after both resets, now at slow timing
		slow_mode = 1'b1;
		op(GO, 8'h00, 1'b0, 1'b0);
		op(WR, 8'hAA, 1'b0, 1'b1);
		stop_idle();
		end_sim();
	end
endmodule // serial_ram_i2c_slave_tb
`default_nettype wire

/* File: verilog/byte_fifo.sv */
// Purpose: small valid/ready fifo
// Assumes: one clock
// Notes: depth a power of two
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_reg;
	logic [AW:0] rd_reg;
	wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	wire empty = wr_reg == rd_reg;
	wire push = in_valid && !full;
	wire pop = out_valid && out_ready;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_reg[AW-1:0]];
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (push) wr_reg <= wr_reg + 1'b1;
			if (pop) rd_reg <= rd_reg + 1'b1;
		end
	end
endmodule // byte_fifo
`default_nettype wire

/* File: verilog/serial_ram_device.sv */
// Purpose: ram end of the two-wire link, 256 bytes
// Assumes: lines sampled on the 40 MHz clock through two flops
// Notes: write data passes a small fifo into the ram
`timescale 1ns/1ps
`default_nettype none
module serial_ram_device #(
	parameter int WORDS = 256
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic power_low,
	input wire logic power_save,
	input wire logic [2:0] hardware_address_straps,
	two_wire_if.device bus,
	output logic busy,
	output logic [7:0] last_word_address
);
	typedef enum {IDLE, ADDR, ADDR_ACK, WPTR, WPTR_ACK, WDATA, WDATA_ACK, RDATA, RACK, IGNORE} state_t;
	state_t state_reg;
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_reg;
	logic sda_reg;
	logic [2:0] straps_reg;
	logic [7:0] shift_reg;
	logic [2:0] count_reg;
	logic [7:0] ptr_reg;
	logic [7:0] out_reg;
	logic sda_low_reg;
	logic [7:0] ram [WORDS];
	// supply loss and power save both reset the bus logic
	wire bus_rst = rst | power_low | power_save;
	always_ff @(posedge clock or posedge bus_rst) begin
		if (bus_rst) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			scl_reg <= scl_sync_reg[1];
			sda_reg <= sda_sync_reg[1];
		end
	end
	wire scl_now = scl_sync_reg[1];
	wire sda_now = sda_sync_reg[1];
	// pure edge detection keeps timing independent of bus speed
	wire scl_rise = scl_now & ~scl_reg;
	wire scl_fall = ~scl_now & scl_reg;
	wire start_seen = scl_now & scl_reg & sda_reg & ~sda_now;
	wire stop_seen = scl_now & scl_reg & ~sda_reg & sda_now;
	wire [7:0] shifted = {shift_reg[6:0], sda_now};
	wire addr_match = shifted[7:4] == serial_ram_pkg::GROUP_ADDRESS
		&& shifted[3:1] == straps_reg;
	wire last_bit = count_reg == 3'h7;
	// the ninth bit must not shift in, or the ack would overwrite the direction bit
	wire ack_phase = state_reg == ADDR_ACK || state_reg == WPTR_ACK
		|| state_reg == WDATA_ACK || state_reg == RACK;
	// at a falling edge the rise counter has wrapped to zero after eight bits
	wire read_byte_done = count_reg == 3'h0;
	wire [2:0] read_index = 3'h7 - count_reg;
	logic fifo_ready;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic [7:0] wr_ptr_reg;
	wire wdata_done = state_reg == WDATA && scl_rise && last_bit;
	byte_fifo #(.WIDTH(8), .DEPTH(serial_ram_pkg::FIFO_DEPTH)) write_fifo (
		.clock(clock),
		.rst(bus_rst),
		.in_valid(wdata_done),
		.in_ready(fifo_ready),
		.in_data(shifted),
		.out_valid(fifo_valid),
		.out_ready(1'b1),
		.out_data(fifo_data)
	);
	always_ff @(posedge clock) begin
		if (fifo_valid) ram[wr_ptr_reg] <= fifo_data;
	end
	// straps are caught by a clocked load on every cycle, with no reset
	always_ff @(posedge clock) begin
		straps_reg <= hardware_address_straps;
	end
	always_ff @(posedge clock or posedge bus_rst) begin
		if (bus_rst) begin
			state_reg <= IDLE;
			shift_reg <= 8'h00;
			count_reg <= 3'h0;
			ptr_reg <= 8'h00;
			wr_ptr_reg <= 8'h00;
			out_reg <= 8'h00;
			sda_low_reg <= 1'b0;
		end else begin
			if (fifo_valid) wr_ptr_reg <= wr_ptr_reg + 8'h01;
			if (start_seen) begin
				state_reg <= ADDR;
				count_reg <= 3'h0;
				sda_low_reg <= 1'b0;
			end else if (stop_seen) begin
				state_reg <= IDLE;
				sda_low_reg <= 1'b0;
			end else begin
				if (scl_rise) begin
					if (!ack_phase) shift_reg <= shifted;
					count_reg <= count_reg + 3'h1;
				end
				unique case (state_reg)
					IDLE, IGNORE: ;
					ADDR: if (scl_rise && last_bit) begin
						state_reg <= addr_match ? ADDR_ACK : IGNORE;
						if (addr_match && shifted[0]) out_reg <= ram[ptr_reg];
					end
					ADDR_ACK, WPTR_ACK, WDATA_ACK: begin
						// pull low from the falling edge after bit eight to the next fall
						if (scl_fall && !sda_low_reg) sda_low_reg <= 1'b1;
						else if (scl_fall) begin
							sda_low_reg <= 1'b0;
							count_reg <= 3'h0;
							if (state_reg == ADDR_ACK)
								state_reg <= shift_reg[0] ? RDATA : WPTR;
							else
								state_reg <= WDATA;
							if (state_reg == ADDR_ACK && shift_reg[0])
								sda_low_reg <= ~out_reg[7];
						end
					end
					WPTR: if (scl_rise && last_bit) begin
						ptr_reg <= shifted;
						wr_ptr_reg <= shifted;
						state_reg <= WPTR_ACK;
					end
					WDATA: if (scl_rise && last_bit) begin
						ptr_reg <= ptr_reg + 8'h01;
						state_reg <= WDATA_ACK;
					end
					RDATA: if (scl_fall) begin
						if (read_byte_done) begin
							sda_low_reg <= 1'b0;
							ptr_reg <= ptr_reg + 8'h01;
							out_reg <= ram[ptr_reg + 8'h01];
							state_reg <= RACK;
						end else begin
							sda_low_reg <= ~out_reg[read_index];
						end
					end
					RACK: begin
						if (scl_rise) state_reg <= sda_now ? IGNORE : RACK;
						if (scl_fall) begin
							state_reg <= RDATA;
							count_reg <= 3'h0;
							sda_low_reg <= ~out_reg[7];
						end
					end
				endcase
			end
		end
	end
	assign bus.sda_s_o = 1'b0;
	assign bus.sda_s_oe = sda_low_reg;
	assign busy = state_reg != IDLE;
	assign last_word_address = ptr_reg;
endmodule // serial_ram_device
`default_nettype wire

/* File: verilog/serial_ram_master.sv */
// Purpose: bus master end, one byte per command
// Assumes: user issues start, byte and stop commands in order
// Notes: clock made by a quarter-bit divider; slow mode stretches it
`timescale 1ns/1ps
`default_nettype none
module serial_ram_master (
	input wire logic clock,
	input wire logic rst,
	input wire logic slow_mode,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ack,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_ack,
	two_wire_if.master bus
);
	// cmd_op: 0 start, 1 write byte, 2 read byte, 3 stop
	typedef enum {IDLE, START, BITS, STOP} state_t;
	state_t state_reg;
	logic [16:0] div_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_reg;
	logic [8:0] tx_reg;
	logic [8:0] rx_reg;
	logic scl_reg;
	logic sda_reg;
	logic read_reg;
	logic [1:0] sync_reg;
	wire [16:0] quarter = slow_mode ? 17'(serial_ram_pkg::SLOW_QUARTER)
		: 17'(serial_ram_pkg::FAST_QUARTER);
	wire tick = div_reg == 17'h00000;
	assign cmd_ready = state_reg == IDLE;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) sync_reg <= 2'h3;
		else sync_reg <= {sync_reg[0], bus.sda};
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= IDLE;
			div_reg <= 17'h00000;
			phase_reg <= 2'h0;
			bit_reg <= 4'h0;
			tx_reg <= 9'h1FF;
			rx_reg <= 9'h000;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			read_reg <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_ack <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			div_reg <= tick ? quarter : div_reg - 17'h00001;
			unique case (state_reg)
				IDLE: if (cmd_valid) begin
					phase_reg <= 2'h0;
					bit_reg <= 4'h0;
					read_reg <= cmd_op == 2'h2;
					// read: release eight bits, drive ack per user (no ack ends read)
					tx_reg <= (cmd_op == 2'h2) ? {8'hFF, ~cmd_ack} : {cmd_data, 1'b1};
					if (cmd_op == 2'h0) state_reg <= START;
					else if (cmd_op == 2'h3) state_reg <= STOP;
					else state_reg <= BITS;
				end
				START: if (tick) begin
					phase_reg <= phase_reg + 2'h1;
					if (phase_reg == 2'h0) sda_reg <= 1'b1;
					if (phase_reg == 2'h1) scl_reg <= 1'b1;
					if (phase_reg == 2'h2) sda_reg <= 1'b0;
					if (phase_reg == 2'h3) begin
						scl_reg <= 1'b0;
						state_reg <= IDLE;
					end
				end
				BITS: if (tick) begin
					phase_reg <= phase_reg + 2'h1;
					// data changes only while the clock is low
					if (phase_reg == 2'h0) sda_reg <= tx_reg[8];
					if (phase_reg == 2'h1) scl_reg <= 1'b1;
					if (phase_reg == 2'h2) rx_reg <= {rx_reg[7:0], sync_reg[1]};
					if (phase_reg == 2'h3) begin
						scl_reg <= 1'b0;
						tx_reg <= {tx_reg[7:0], 1'b1};
						bit_reg <= bit_reg + 4'h1;
						if (bit_reg == 4'h8) begin
							sda_reg <= 1'b1;
							state_reg <= IDLE;
							rsp_valid <= 1'b1;
							rsp_data <= rx_reg[8:1];
							rsp_ack <= ~rx_reg[0];
						end
					end
				end
				STOP: if (tick) begin
					phase_reg <= phase_reg + 2'h1;
					if (phase_reg == 2'h0) sda_reg <= 1'b0;
					if (phase_reg == 2'h1) scl_reg <= 1'b1;
					if (phase_reg == 2'h2) sda_reg <= 1'b1;
					if (phase_reg == 2'h3) state_reg <= IDLE;
				end
			endcase
		end
	end
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = ~scl_reg;
	assign bus.sda_m_o = 1'b0;
	assign bus.sda_m_oe = ~sda_reg;
endmodule // serial_ram_master
`default_nettype wire

/* File: verilog/serial_ram_pkg.sv */
// Purpose: shared constants for the two-wire serial ram link
// Assumes: 40 MHz system clock on both ends
// Notes: the master end derives the bus clock from a divider
`default_nettype none
package serial_ram_pkg;
	localparam int CLOCK_HZ = 40_000_000;
	localparam logic [3:0] GROUP_ADDRESS = 4'hA;
	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 8;
	localparam int BITS_PER_BYTE = 8;
	localparam int FAST_LOW_NS = 4700;
	localparam int SLOW_LOW_NS = 130000;
	localparam int FAST_QUARTER = (FAST_LOW_NS * 40 + 3999) / 4000 + 1;
	localparam int SLOW_QUARTER = (SLOW_LOW_NS * 40 + 3999) / 4000;
	localparam int FIFO_DEPTH = 4;
endpackage
`default_nettype wire

/* File: verilog/two_wire_if.sv */
// Purpose: joins the bus master end and the ram end
// Assumes: open-drain lines with pull-ups
// Notes: a line is low when any end enables its driver
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	wire scl = ~((scl_oe & ~scl_o));
	wire sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
	modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
		input scl, input sda);
	modport device (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface
`default_nettype wire
